// ---- acc_ctrl.sv ----
// Purpose: per-master control bits, idle disconnect, soft-reset SCL hold, bus init
// Assumes: register strobes, grant and lock request come from logic on i_mclk
// Notes:   init sequencer runs on the link clock; pins are open drain (oe = drive low)

// Contract
// - with idle disconnect enabled and reserve expired, 100 ms of bus idle revokes grant and opens switch.
// - a grant with zero reserve interval starts the idle disconnect at once.
// - a soft reset with the hold enable set clears all bits and then holds SCL low 35 ms.
// - a general-call soft reset from either master triggers the hold, granted or not.
// - init issues one SCL clock, samples SDA, and if high sends a NACK and a STOP.
// - while SDA stays low another clock is issued, up to 9, then init is failed.
// - the init bit takes effect at the next connection of the downstream bus.
// - a master's switch closes only while its connect bit and its lock grant are both 1.
// - the lock grant bit is read only and shows ownership of the downstream bus.
// - after any reset the grant and the four control bits read 0.
// - each master has its own copy of the control register, chosen by the accessing channel.
// - a master dropping its lock request loses its grant and its switch opens.
module acc_ctrl #(
	parameter int P_IDLE_CYC = acc_pkg::IDLE_CYC,
	parameter int P_HOLD_CYC = acc_pkg::HOLD_CYC
) (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_link_clk,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_ch,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic [1:0] i_lock_req,
	input  wire logic [1:0] i_grant_set,
	input  wire logic [1:0] i_res_expired,
	input  wire logic [1:0] i_res_zero,
	input  wire logic       i_soft_rst,
	input  wire logic       i_scl_i,
	input  wire logic       i_sda_i,
	output logic [7:0]      o_ctrl_rd0,
	output logic [7:0]      o_ctrl_rd1,
	output logic [1:0]      o_switch,
	output logic [1:0]      o_idle_revoke,
	output logic            o_init_done,
	output logic            o_init_fail,
	output logic            o_scl_o,
	output logic            o_scl_oe,
	output logic            o_sda_o,
	output logic            o_sda_oe
);
	localparam logic [acc_pkg::CNT_W-1:0] IDLE_LAST = acc_pkg::CNT_W'(P_IDLE_CYC - 1);
	localparam logic [acc_pkg::CNT_W-1:0] HOLD_LOAD = acc_pkg::CNT_W'(P_HOLD_CYC);

	// main domain state
	logic [1:0][3:0]             ctrl_q, ctrl_d;   // bits 5..2 per master
	logic [1:0]                  grant_q, grant_d;
	logic [1:0]                  sw_q, sw_d;
	logic [1:0]                  revoke_q, revoke_d;
	logic [7:0]                  rd0_q, rd0_d, rd1_q, rd1_d;
	logic [acc_pkg::CNT_W-1:0]   idle_cnt_q, idle_cnt_d;
	logic [acc_pkg::CNT_W-1:0]   hold_cnt_q, hold_cnt_d;
	logic                        init_tgl_q, init_tgl_d;
	logic                        done_seen_q, done_seen_d;
	logic                        done_q, done_d;
	logic                        fail_out_q, fail_out_d;
	logic [1:0]                  pins_s;
	logic [1:0]                  pins_prev_q;
	logic [1:0]                  back_s;
	logic                        bus_edge;
	logic                        idle_arm;
	logic                        idle_fire;

	// link domain state
	acc_pkg::acc_lstate_t        lst_q, lst_d;
	logic [3:0]                  nclk_q, nclk_d;
	logic [1:0]                  wait_q, wait_d;
	logic                        lfail_q, lfail_d;
	logic                        ldone_q, ldone_d;
	logic                        ltgl_seen_q, ltgl_seen_d;
	logic                        seq_scl_q, seq_scl_d;
	logic                        seq_sda_q, seq_sda_d;
	logic                        scl_oe_q, scl_oe_d;
	logic                        sda_oe_q, sda_oe_d;
	logic                        link_rst;
	logic [2:0]                  fwd_s;            // rst, hold, init toggle
	logic                        sda_l;

	// downstream pins into the device clock domain
	// pins keep tracking through reset so no false edge follows its release
	acc_sync #(.W(2)) u_pin_sync (
		.i_clk (i_mclk),
		.i_rst (1'b0),
		.i_d   ({i_scl_i, i_sda_i}),
		.o_q   (pins_s)
	);

	// init result back from the link domain: fail level settles before the toggle moves
	acc_sync #(.W(2)) u_back_sync (
		.i_clk (i_mclk),
		.i_rst (i_rst),
		.i_d   ({ldone_q, lfail_q}),
		.o_q   (back_s)
	);

	// reset, hold level and init request toward the link domain
	acc_sync #(.W(3)) u_fwd_sync (
		.i_clk (i_link_clk),
		.i_rst (1'b0),
		.i_d   ({i_rst, (hold_cnt_q != '0), init_tgl_q}),
		.o_q   (fwd_s)
	);

	acc_sync #(.W(1)) u_sda_sync (
		.i_clk (i_link_clk),
		.i_rst (link_rst),
		.i_d   (i_sda_i),
		.o_q   (sda_l)
	);

	assign link_rst = fwd_s[2];

	// idle detection on the synchronised pins
	assign bus_edge  = (pins_s != pins_prev_q);
	assign idle_arm  = |(grant_q & {ctrl_q[1][3], ctrl_q[0][3]} & (i_res_expired | i_res_zero));
	assign idle_fire = idle_arm && !bus_edge && (idle_cnt_q == IDLE_LAST);

	// control bits, grants, switches and timers
	always_comb begin
		ctrl_d      = ctrl_q;
		grant_d     = grant_q;
		revoke_d    = 2'b00;
		init_tgl_d  = init_tgl_q;
		done_seen_d = back_s[1];
		done_d      = back_s[1] != done_seen_q;
		fail_out_d  = fail_out_q;
		hold_cnt_d  = (hold_cnt_q != '0) ? hold_cnt_q - 1'b1 : hold_cnt_q;
		idle_cnt_d  = (!idle_arm || bus_edge || idle_fire) ? '0 : idle_cnt_q + 1'b1;
		if (done_d) begin
			fail_out_d = back_s[0];
		end
		// each master writes only its own copy; the grant bit is not writable
		if (i_reg_wr) begin
			ctrl_d[i_reg_ch] = i_reg_wdata[acc_pkg::IDLE_EN_BIT:acc_pkg::CONNECT_BIT];
		end
		for (int i = 0; i < 2; i++) begin
			if (i_grant_set[i] && i_lock_req[i]) begin
				grant_d[i] = 1'b1;
			end
			if (!i_lock_req[i]) begin
				grant_d[i] = 1'b0;
			end
			if (idle_fire && grant_q[i]) begin
				grant_d[i] = 1'b0;
				revoke_d[i] = 1'b1;
			end
		end
		// soft reset from either master clears control bits, grants and the idle timer; hold decided from old bits
		if (i_soft_rst) begin
			ctrl_d     = '0;
			grant_d    = 2'b00;
			idle_cnt_d = '0;
			revoke_d   = 2'b00;
			if (ctrl_q[0][2] || ctrl_q[1][2]) begin
				hold_cnt_d = HOLD_LOAD;
			end
		end
		for (int i = 0; i < 2; i++) begin
			sw_d[i] = ctrl_d[i][0] && grant_d[i];
		end
		// init launches on a fresh connection, not on the write
		for (int i = 0; i < 2; i++) begin
			if (sw_d[i] && !sw_q[i] && ctrl_d[i][1]) begin
				init_tgl_d = ~init_tgl_q;
				ctrl_d[i][1] = 1'b0;
			end
		end
		rd0_d = {2'b00, ctrl_d[0], grant_d[0], 1'b0};
		rd1_d = {2'b00, ctrl_d[1], grant_d[1], 1'b0};
		if (i_rst) begin
			ctrl_d      = '0;
			grant_d     = 2'b00;
			sw_d        = 2'b00;
			revoke_d    = 2'b00;
			rd0_d       = acc_pkg::CTRL_RESET;
			rd1_d       = acc_pkg::CTRL_RESET;
			idle_cnt_d  = '0;
			hold_cnt_d  = '0;
			init_tgl_d  = 1'b0;
			done_seen_d = 1'b0;
			done_d      = 1'b0;
			fail_out_d  = 1'b0;
		end
	end

	// main domain registers
	always_ff @(posedge i_mclk) begin
		ctrl_q      <= ctrl_d;
		grant_q     <= grant_d;
		sw_q        <= sw_d;
		revoke_q    <= revoke_d;
		rd0_q       <= rd0_d;
		rd1_q       <= rd1_d;
		idle_cnt_q  <= idle_cnt_d;
		hold_cnt_q  <= hold_cnt_d;
		init_tgl_q  <= init_tgl_d;
		done_seen_q <= done_seen_d;
		done_q      <= done_d;
		fail_out_q  <= fail_out_d;
		pins_prev_q <= i_rst ? 2'b11 : pins_s;
	end

	// init sequencer, one bus phase per link clock, four for the sampled SCL high phase
	always_comb begin
		lst_d       = lst_q;
		nclk_d      = nclk_q;
		wait_d      = wait_q;
		lfail_d     = lfail_q;
		ldone_d     = ldone_q;
		ltgl_seen_d = fwd_s[0];
		seq_scl_d   = 1'b0;
		seq_sda_d   = 1'b0;
		case (lst_q)
			acc_pkg::L_IDLE: begin
				nclk_d = 4'h0;
				if (fwd_s[0] != ltgl_seen_q) begin
					lfail_d = 1'b0;
					lst_d   = acc_pkg::L_LOW;
				end
			end
			acc_pkg::L_LOW: begin
				seq_scl_d = 1'b1;
				nclk_d    = nclk_q + 4'h1;
				wait_d    = 2'h0;
				lst_d     = acc_pkg::L_HIGH;
			end
			acc_pkg::L_HIGH: begin
				// wait out the sync latency before trusting sda
				wait_d = wait_q + 2'h1;
				if (wait_q == acc_pkg::SAMPLE_WAIT) begin
					if (sda_l) begin
						lst_d = acc_pkg::L_NACK_LO;
					end else if (nclk_q == acc_pkg::INIT_MAX_CLK) begin
						lfail_d = 1'b1;
						lst_d   = acc_pkg::L_DONE;
					end else begin
						lst_d = acc_pkg::L_LOW;
					end
				end
			end
			acc_pkg::L_NACK_LO: begin
				seq_scl_d = 1'b1;
				lst_d     = acc_pkg::L_NACK_HI;
			end
			acc_pkg::L_NACK_HI: begin
				lst_d = acc_pkg::L_STP_LO;
			end
			acc_pkg::L_STP_LO: begin
				seq_scl_d = 1'b1;
				seq_sda_d = 1'b1;
				lst_d     = acc_pkg::L_STP_HI;
			end
			acc_pkg::L_STP_HI: begin
				seq_sda_d = 1'b1;
				lst_d     = acc_pkg::L_DONE;
			end
			acc_pkg::L_DONE: begin
				ldone_d = ~ldone_q;
				lst_d   = acc_pkg::L_IDLE;
			end
			default: begin
				lst_d = acc_pkg::L_IDLE;
			end
		endcase
		scl_oe_d = seq_scl_d || fwd_s[1];
		sda_oe_d = seq_sda_d;
		if (link_rst) begin
			lst_d       = acc_pkg::L_IDLE;
			nclk_d      = 4'h0;
			wait_d      = 2'h0;
			lfail_d     = 1'b0;
			ldone_d     = 1'b0;
			ltgl_seen_d = 1'b0;
			seq_scl_d   = 1'b0;
			seq_sda_d   = 1'b0;
			scl_oe_d    = 1'b0;
			sda_oe_d    = 1'b0;
		end
	end

	// link domain registers
	always_ff @(posedge i_link_clk) begin
		lst_q       <= lst_d;
		nclk_q      <= nclk_d;
		wait_q      <= wait_d;
		lfail_q     <= lfail_d;
		ldone_q     <= ldone_d;
		ltgl_seen_q <= ltgl_seen_d;
		seq_scl_q   <= seq_scl_d;
		seq_sda_q   <= seq_sda_d;
		scl_oe_q    <= scl_oe_d;
		sda_oe_q    <= sda_oe_d;
	end

	assign o_ctrl_rd0    = rd0_q;
	assign o_ctrl_rd1    = rd1_q;
	assign o_switch      = sw_q;
	assign o_idle_revoke = revoke_q;
	assign o_init_done   = done_q;
	assign o_init_fail   = fail_out_q;
	assign o_scl_o       = 1'b0;
	assign o_sda_o       = 1'b0;
	assign o_scl_oe      = scl_oe_q;
	assign o_sda_oe      = sda_oe_q;

	// checks in the device clock domain, except a_fail_nine on the link clock
	property p_switch_gate;
		@(posedge i_mclk) disable iff (i_rst)
		o_switch[0] == (o_ctrl_rd0[acc_pkg::CONNECT_BIT] && o_ctrl_rd0[acc_pkg::GRANT_BIT]);
	endproperty
	a_switch_gate: assert property (p_switch_gate) else $error("switch without connect and grant");

	property p_req_drop;
		@(posedge i_mclk) disable iff (i_rst)
		!i_lock_req[1] |=> !o_ctrl_rd1[acc_pkg::GRANT_BIT] && !o_switch[1];
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("grant kept after request dropped");

	property p_reset_clear;
		@(posedge i_mclk) disable iff (i_rst)
		$fell(i_rst) |-> o_ctrl_rd0 == 8'h00 && o_ctrl_rd1 == 8'h00 && o_switch == 2'b00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("bits not clear after reset");

	property p_soft_hold;
		@(posedge i_mclk) disable iff (i_rst)
		i_soft_rst && (ctrl_q[0][2] || ctrl_q[1][2])
			|=> hold_cnt_q == HOLD_LOAD && o_ctrl_rd0 == 8'h00 && o_ctrl_rd1 == 8'h00;
	endproperty
	a_soft_hold: assert property (p_soft_hold) else $error("soft reset hold not loaded");

	property p_soft_any;
		@(posedge i_mclk) disable iff (i_rst)
		i_soft_rst && !ctrl_q[0][2] && !ctrl_q[1][2] && hold_cnt_q == '0 |=> hold_cnt_q == '0;
	endproperty
	a_soft_any: assert property (p_soft_any) else $error("hold started without enable");

	property p_idle_fire;
		@(posedge i_mclk) disable iff (i_rst)
		idle_fire && grant_q[0] && !i_soft_rst |=> !grant_q[0] && o_idle_revoke[0] && !o_switch[0];
	endproperty
	a_idle_fire: assert property (p_idle_fire) else $error("idle expiry did not revoke");

	property p_zero_reserve;
		@(posedge i_mclk) disable iff (i_rst)
		grant_q[0] && ctrl_q[0][3] && i_res_zero[0] && !bus_edge && !idle_fire && !i_soft_rst
			|=> idle_cnt_q == $past(idle_cnt_q) + 1'b1;
	endproperty
	a_zero_reserve: assert property (p_zero_reserve) else $error("idle timer idle at zero reserve");

	property p_edge_restart;
		@(posedge i_mclk) disable iff (i_rst)
		bus_edge |=> idle_cnt_q == '0;
	endproperty
	a_edge_restart: assert property (p_edge_restart) else $error("idle timer not restarted");

	property p_init_on_connect;
		@(posedge i_mclk) disable iff (i_rst)
		$changed(init_tgl_q) |-> $rose(o_switch[0]) || $rose(o_switch[1]);
	endproperty
	a_init_on_connect: assert property (p_init_on_connect) else $error("init not at connect");

	property p_fail_nine;
		@(posedge i_link_clk) disable iff (link_rst)
		$rose(lfail_q) |-> nclk_q == acc_pkg::INIT_MAX_CLK && !$past(sda_l);
	endproperty
	a_fail_nine: assert property (p_fail_nine) else $error("init failed at wrong clock count");

	c_soft_hold: cover property (@(posedge i_mclk) disable iff (i_rst) hold_cnt_q == HOLD_LOAD);
	c_idle_fire: cover property (@(posedge i_mclk) disable iff (i_rst) |o_idle_revoke);
	c_init_done: cover property (@(posedge i_mclk) disable iff (i_rst) o_init_done && !o_init_fail);
endmodule

// ---- acc_pkg.sv ----
// Purpose: shared constants for the arbiter channel control bits
// Assumes: 25 MHz device clock
// Notes:   times kept in microseconds, cycle counts derived here
package acc_pkg;
	// control register field positions
	localparam int IDLE_EN_BIT   = 5;
	localparam int HOLD_EN_BIT   = 4;
	localparam int INIT_BIT      = 3;
	localparam int CONNECT_BIT   = 2;
	localparam int GRANT_BIT     = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// timing
	localparam int CLK_MHZ       = 25;
	localparam int IDLE_TIME_US  = 100000;
	localparam int HOLD_TIME_US  = 35000;
	localparam int IDLE_CYC      = IDLE_TIME_US * CLK_MHZ;
	localparam int HOLD_CYC      = HOLD_TIME_US * CLK_MHZ;
	localparam int CNT_W         = 22;
	// downstream init sequence
	localparam logic [3:0] INIT_MAX_CLK = 4'h9;
	localparam logic [1:0] SAMPLE_WAIT  = 2'h3;
	typedef enum logic [2:0] {
		L_IDLE    = 3'b000,
		L_LOW     = 3'b001,
		L_HIGH    = 3'b010,
		L_NACK_LO = 3'b011,
		L_NACK_HI = 3'b100,
		L_STP_LO  = 3'b101,
		L_STP_HI  = 3'b110,
		L_DONE    = 3'b111
	} acc_lstate_t;
endpackage

// ---- acc_sync.sv ----
// Purpose: two flip-flop synchroniser, one chain per bit
// Assumes: inputs are levels or toggles, never single pulses
// Notes:   first stage is read only by the second stage
module acc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// next values of both stages
	always_comb begin
		meta_d = i_d;
		sync_d = meta_q;
		if (i_rst) begin
			meta_d = '0;
			sync_d = '0;
		end
	end

	// register both stages
	always_ff @(posedge i_clk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign o_q = sync_q;
endmodule

// ---- acc_bus_model.sv ----
// Purpose: downstream bus with pull-ups and a slave that may hold SDA low
// Assumes: design pins are open drain, oe high pulls the line low
// Notes:   stuck slave lets go after a set count of SCL falls
module acc_bus_model (
	input  wire logic       i_scl_oe,
	input  wire logic       i_sda_oe,
	input  wire logic       i_poke,
	input  wire logic       i_clear,
	input  wire logic [3:0] i_stuck,
	output logic            o_scl,
	output logic            o_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	int falls = 0;
	// clocks seen since the bench cleared us, counted on the wire itself
	always @(negedge o_scl or posedge i_clear) begin
		if (i_clear)
			falls = 0;
		else
			falls = falls + 1;
	end
	// pull-ups win unless a party pulls low; released lines never keep old values
	assign o_scl = ~i_scl_oe;
	// a stuck slave keeps sda low through the first i_stuck clocks it sees
	assign o_sda = ~(i_sda_oe | i_poke | (i_stuck != 4'h0 && falls <= int'(i_stuck)));
endmodule

// ---- acc_ctrl_tb.sv ----
// Purpose: self-checking bench for the arbiter channel control bits
// Assumes: short idle and hold counts so the run stays brief
// Notes:   expectations come from the counts set here, never from outputs
module acc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IDLE = 16;
	localparam int HOLD = 20;
	logic       mclk = 0, link_clk = 0, rst = 1, reg_wr = 0, reg_ch = 0, soft_rst = 0;
	logic       poke = 0, clear = 0, scl, sda, done, fail, scl_oe, sda_oe;
	logic [1:0] lock_req = 0, grant_set = 0, res_exp = 0, res_zero = 0, sw, revoke;
	logic [3:0] stuck = 0;
	logic [7:0] wdata = 0, rd0, rd1;
	int         fails = 0, n_compared = 0, n_falls = 0, n_done = 0, n_rev = 0;

	// two unrelated clocks, 40 ns device and 48 ns link
	always #20 mclk = ~mclk;
	always #24 link_clk = ~link_clk;
	// event counters on what the design drives
	always @(negedge scl) n_falls++;
	always @(posedge mclk) if (done === 1'b1) n_done++;
	always @(posedge mclk) if (revoke !== 2'b00) n_rev++;

	acc_ctrl #(.P_IDLE_CYC(IDLE), .P_HOLD_CYC(HOLD)) DUT (
		.i_mclk(mclk), .i_rst(rst), .i_link_clk(link_clk), .i_reg_wr(reg_wr),
		.i_reg_ch(reg_ch), .i_reg_wdata(wdata), .i_lock_req(lock_req),
		.i_grant_set(grant_set), .i_res_expired(res_exp), .i_res_zero(res_zero),
		.i_soft_rst(soft_rst), .i_scl_i(scl), .i_sda_i(sda), .o_ctrl_rd0(rd0),
		.o_ctrl_rd1(rd1), .o_switch(sw), .o_idle_revoke(revoke), .o_init_done(done),
		.o_init_fail(fail), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(), .o_sda_oe(sda_oe));
	acc_bus_model bus (
		.i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_poke(poke), .i_clear(clear),
		.i_stuck(stuck), .o_scl(scl), .o_sda(sda));

	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// wide enough for the paired read image and switch compares
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bail;
		fails++;
		$display("Error at %0t: wait ran out", $time);
		results();
	endtask
	// inputs move 1 ns after the edge, so no race with the design
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic ch, input logic [7:0] d);
		reg_wr = 1;
		reg_ch = ch;
		wdata = d;
		tick(1);
		reg_wr = 0;
	endtask
	task automatic grant(input int m);
		lock_req[m] = 1;
		grant_set[m] = 1;
		tick(1);
		grant_set[m] = 0;
		tick(1);
	endtask
	// revoke must land inside a window around the idle count
	task automatic await_rev;
		int i;
		i = 0;
		while (revoke === 2'b00 && i < 80) begin
			tick(1);
			i++;
		end
		if (i == 80) bail();
		chk({7'h0, i >= IDLE - 2 && i <= IDLE + 6}, 8'h01);
		tick(1);
		chk({rd0, 6'h0, sw}, {8'h24, 8'h00});
	endtask

	task automatic t_regs;
		wr(0, 8'hf7);
		wr(1, 8'h28);
		tick(1);
		chk(rd0, 8'h34);
		chk(rd1, 8'h28);
		wr(0, 8'h00);
		wr(1, 8'h00);
	endtask
	task automatic t_switch;
		wr(0, 8'h04);
		grant_set[1] = 1;
		tick(1);
		grant_set[1] = 0;
		tick(1);
		chk({6'h0, sw}, 8'h00);
		chk(rd1, 8'h00);
		grant(0);
		chk({rd0, 6'h0, sw}, {8'h06, 8'h01});
		wr(0, 8'h00);
		tick(1);
		chk({rd0, 6'h0, sw}, {8'h02, 8'h00});
		wr(0, 8'h04);
		lock_req[0] = 0;
		tick(2);
		chk({rd0, 6'h0, sw}, {8'h04, 8'h00});
	endtask
	task automatic t_idle;
		int r0;
		wr(0, 8'h24);
		grant(0);
		r0 = n_rev;
		tick(40);
		res_exp[0] = 1;
		repeat (6) begin
			tick(7);
			poke = 1;
			tick(1);
			poke = 0;
		end
		chk(8'(n_rev - r0), 8'h00);
		await_rev();
		res_exp[0] = 0;
		res_zero[0] = 1;
		grant(0);
		await_rev();
		res_zero[0] = 0;
		lock_req[0] = 0;
		wr(0, 8'h00);
	endtask
	task automatic t_init(input logic [3:0] k, input int pulses, input logic f);
		int i;
		int d0;
		stuck = k;
		clear = 1;
		tick(1);
		clear = 0;
		n_falls = 0;
		d0 = n_done;
		wr(0, 8'h0c);
		tick(60);
		chk(8'(n_falls + n_done - d0), 8'h00);
		grant(0);
		i = 0;
		while (done !== 1'b1 && i < 3000) begin
			tick(1);
			i++;
		end
		if (i == 3000) bail();
		chk({7'h0, fail}, {7'h0, f});
		tick(4);
		chk(8'(n_falls), 8'(pulses));
		chk(rd0, 8'h06);
		lock_req[0] = 0;
		tick(2);
	endtask
	task automatic t_soft;
		int i;
		wr(1, 8'h10);
		wr(0, 8'h04);
		grant(0);
		soft_rst = 1;
		tick(1);
		soft_rst = 0;
		tick(1);
		chk({rd0, rd1}, 16'h0000);
		chk({6'h0, sw}, 8'h00);
		i = 0;
		while (scl_oe !== 1'b1 && i < 20) begin
			tick(1);
			i++;
		end
		if (i == 20) bail();
		i = 0;
		while (scl_oe === 1'b1 && i < 100) begin
			tick(1);
			i++;
		end
		chk({7'h0, i >= HOLD - 2 && i <= HOLD + 6}, 8'h01);
		lock_req[0] = 0;
		n_falls = 0;
		soft_rst = 1;
		tick(1);
		soft_rst = 0;
		tick(40);
		chk(8'(n_falls), 8'h00);
	endtask
	task automatic t_rst;
		wr(0, 8'h3c);
		wr(1, 8'h34);
		grant(1);
		rst = 1;
		tick(20);
		rst = 0;
		lock_req[1] = 0;
		tick(1);
		chk({rd0, rd1}, 16'h0000);
		chk({2'h0, sw, fail, done, scl_oe, sda_oe}, 8'h00);
	endtask

	// main sequence, reset held for 20 cycles first
	initial begin
		tick(20);
		rst = 0;
		tick(1);
		chk({rd0, rd1}, 16'h0000);
		t_regs();
		t_switch();
		t_idle();
		t_init(4'h0, 3, 1'b0);
		t_init(4'h3, 6, 1'b0);
		t_init(4'h8, 11, 1'b0);
		t_init(4'h9, 9, 1'b1);
		t_soft();
		t_rst();
		results();
	end
endmodule
